// file: verilog/gtcu_defs.svh
// Purpose: offsets, field positions and reset values of the timer counting unit
// Assumes: byte addresses on an 8-bit AXI4-Lite address
// Notes: every register is one aligned 32-bit word, unused bits read zero
`ifndef GTCU_DEFS_SVH
`define GTCU_DEFS_SVH
`define GTCU_OFF_RELOAD 8'h00
`define GTCU_OFF_COUNT 8'h04
`define GTCU_OFF_CTRL 8'h08
`define GTCU_OFF_ID 8'h0c
`define GTCU_OFF_CHCTL 8'h10
`define GTCU_OFF_MASK 8'h14
`define GTCU_OFF_STATUS 8'h18
`define GTCU_OFF_CLEAR 8'h1c
`define GTCU_OFF_DMA 8'h20
`define GTCU_OFF_CCR0 8'h24
`define GTCU_OFF_CCR1 8'h28
`define GTCU_OFF_CCR2 8'h2c
`define GTCU_OFF_CCR3 8'h30
`define GTCU_B_EN 0
`define GTCU_B_MODE 1
`define GTCU_B_TRS 3
`define GTCU_B_POL 4
`define GTCU_B_SINGLE 5
`define GTCU_B_TOGEN 6
`define GTCU_B_PRS 7
`define GTCU_B_PRSACT 11
`define GTCU_ST_OV 0
`define GTCU_ST_TI 1
`define GTCU_ST_CH0 2
`define GTCU_RST_RELOAD 16'hffff
`define GTCU_RESP_OKAY 2'h0
`define GTCU_RESP_SLVERR 2'h2
`endif

// file: verilog/gtcu_pkg.sv
// Purpose: types shared by the timer counting unit
// Assumes: nothing beyond the defs header
// Notes: mode codes follow declaration order, 0 to 3
package gtcu_pkg;
	typedef enum logic [1:0] {gtcu_m_timer, gtcu_m_count, gtcu_m_trig, gtcu_m_gate} gtcu_mode_t;
	typedef struct packed {
		logic [3:0] prescale_select;
		logic togen;
		logic single;
		logic pol;
		logic trs;
		gtcu_mode_t mode;
		logic en;
	} gtcu_ctrl_t;
	typedef struct packed {
		logic cap;
		logic fall;
	} gtcu_ch_cfg_t;
	typedef struct packed {
		logic [15:0] ccr;
		logic last;
		logic ev;
		logic pwm;
	} gtcu_ch_st_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} gtcu_sync_t;
	typedef struct packed {
		gtcu_ctrl_t ctl;
		logic [15:0] reload_value;
		logic [15:0] cnt;
		logic [3:0] prs_act;
		logic [14:0] psc;
		logic started;
		logic trg_q;
		logic [5:0] status;
		logic [5:0] mask;
		logic [5:0] dma_en;
		logic [7:0] chctl;
		logic tog_p;
		logic tog_n;
		logic ov_pulse;
		logic dma_req;
		logic irq;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gtcu_st_t;
endpackage : gtcu_pkg

// file: verilog/gtcu_sync3.sv
// Purpose: three-stage synchroniser for one pin
// Assumes: pin is asynchronous to aclk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module gtcu_sync3 (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic q
);
	gtcu_pkg::gtcu_sync_t st;
	gtcu_pkg::gtcu_sync_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;
endmodule : gtcu_sync3

// file: verilog/gtcu_channel.sv
// Purpose: one capture/compare channel of the timer
// Assumes: in_lvl already synchronised, tick is the counter's count enable
// Notes: a capture in the same cycle as a software write wins
`timescale 1ns/1ps
module gtcu_channel (
	input wire logic aclk,
	input wire logic aresetn,
	input gtcu_pkg::gtcu_ch_cfg_t cfg,
	input wire logic in_lvl,
	input wire logic [15:0] cnt,
	input wire logic tick,
	input wire logic wr,
	input wire logic [15:0] wdata,
	output logic [15:0] ccr,
	output logic ev,
	output logic pwm
);
	gtcu_pkg::gtcu_ch_st_t st;
	gtcu_pkg::gtcu_ch_st_t next_st;
	logic hit;

	always_comb begin
		next_st = st;
		next_st.ev = 1'b0;
		next_st.last = in_lvl;
		hit = cfg.fall ? (st.last & ~in_lvl) : (~st.last & in_lvl);
		if (wr) begin
			next_st.ccr = wdata;
		end
		if (cfg.cap) begin
			next_st.pwm = 1'b0;
			if (hit) begin
				next_st.ccr = cnt;
				next_st.ev = 1'b1;
			end
		end else begin
			next_st.pwm = (cnt < st.ccr);
			if (tick && cnt == st.ccr) begin
				next_st.ev = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ccr = st.ccr;
	assign ev = st.ev;
	assign pwm = st.pwm;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_capture_value: assert property ((cfg.cap && hit) |=> (ev && ccr == $past(cnt)))
		else $error("capture did not store the count");
	a_compare_event: assert property ((!cfg.cap && tick && cnt == ccr) |=> ev)
		else $error("compare match gave no event");
	c_capture: cover property (cfg.cap && hit ##1 ev);
endmodule : gtcu_channel

// file: verilog/gtcu_top.sv
// Purpose: counting core of one general purpose timer with AXI4-Lite registers
// Assumes: one aclk domain, itr comes from logic on aclk, other inputs are pins
// Notes: build one of these per timer instance, they share nothing
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "gtcu_defs.svh"
module gtcu_top #(
	parameter int unsigned INSTANCE_ID = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic etr,
	input wire logic itr,
	input wire logic [3:0] ch_in,
	output logic [3:0] ch_out,
	output logic tog_p,
	output logic tog_n,
	output logic overflow_pulse,
	output logic dma_req,
	output logic irq
);
	gtcu_pkg::gtcu_st_t st;
	gtcu_pkg::gtcu_st_t next_st;
	logic [4:0] sync_q;
	logic [4:0] pin_raw;
	logic etr_s;
	logic trg;
	logic trg_edge;
	logic gate;
	logic do_wr;
	logic [14:0] pmask;
	logic src;
	logic tick;
	logic ov_evt;
	logic ti_evt;
	logic [5:0] ev;
	logic [5:0] clr;
	logic [15:0] rc;
	logic [15:0] wv;
	logic [31:0] rd;
	logic rd_ok;
	logic [3:0] ch_ev;
	logic [15:0] ch_ccr [4];
	logic [3:0] ch_wr;
	logic [15:0] ch_wd [4];

	function automatic logic [15:0] gtcu_merge(input logic [15:0] o, input logic [15:0] v,
		input logic [1:0] b);
		gtcu_merge = {b[1] ? v[15:8] : o[15:8], b[0] ? v[7:0] : o[7:0]};
	endfunction : gtcu_merge

	// bit 0 is the trigger pin, bits 4:1 the capture pins, so no index runs out of range
	assign pin_raw = {ch_in, etr};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			gtcu_sync3 u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin(pin_raw[gi]),
				.q(sync_q[gi])
			);
		end
		for (gi = 0; gi < 4; gi++) begin : g_ch
			// compare registers live in the channels; the bus only steers the write
			assign ch_wr[gi] = do_wr && st.awaddr == 8'(`GTCU_OFF_CCR0 + 4 * gi);
			assign ch_wd[gi] = gtcu_merge(ch_ccr[gi], st.wdata[15:0], st.wstrb[1:0]);
			gtcu_channel u_ch (
				.aclk(aclk),
				.aresetn(aresetn),
				.cfg(gtcu_pkg::gtcu_ch_cfg_t'(st.chctl[2*gi +: 2])),
				.in_lvl(sync_q[gi+1]),
				.cnt(st.cnt),
				.tick(tick),
				.wr(ch_wr[gi]),
				.wdata(ch_wd[gi]),
				.ccr(ch_ccr[gi]),
				.ev(ch_ev[gi]),
				.pwm(ch_out[gi])
			);
		end
	endgenerate

	assign etr_s = sync_q[0];
	// itr is already on aclk, so it skips the synchroniser
	assign trg = (st.ctl.trs ? itr : etr_s) ^ st.ctl.pol;
	assign trg_edge = trg & ~st.trg_q;
	assign gate = etr_s ^ st.ctl.pol;
	assign do_wr = st.aw_got & st.w_got;
	assign pmask = 15'((16'h0001 << st.prs_act) - 16'h0001);
	assign awready = !st.aw_got && !st.bvalid;
	assign wready = !st.w_got && !st.bvalid;
	assign arready = !st.rvalid;

	always_comb begin
		next_st = st;
		src = 1'b0;
		tick = 1'b0;
		ov_evt = 1'b0;
		ti_evt = 1'b0;
		rc = 16'h0000;
		wv = 16'h0000;
		rd = 32'h00000000;
		rd_ok = 1'b1;
		clr = 6'h00;
		unique case (st.ctl.mode)
			gtcu_pkg::gtcu_m_timer: src = 1'b1;
			gtcu_pkg::gtcu_m_count: src = trg_edge;
			gtcu_pkg::gtcu_m_trig: src = st.started;
			gtcu_pkg::gtcu_m_gate: src = gate;
		endcase
		next_st.trg_q = trg;
		if (!st.ctl.en) begin
			next_st.started = 1'b0;
		end else if (st.ctl.mode == gtcu_pkg::gtcu_m_trig && trg_edge && !st.started) begin
			next_st.started = 1'b1;
			ti_evt = 1'b1;
		end
		// psc counts source events; all-ones under the mask is the divided tick
		tick = st.ctl.en & src & ((st.psc & pmask) == pmask);
		if (st.ctl.en && src) begin
			next_st.psc = tick ? 15'h0000 : 15'(st.psc + 15'h0001);
		end
		if (tick) begin
			// equality against the live reload; a count above it would run to 0xffff
			if (st.cnt == st.reload_value) begin
				ov_evt = 1'b1;
				next_st.cnt = 16'h0000;
				next_st.prs_act = st.ctl.prescale_select;
				next_st.psc = 15'h0000;
				if (st.ctl.single) begin
					next_st.ctl.en = 1'b0;
				end
			end else begin
				next_st.cnt = 16'(st.cnt + 16'h0001);
			end
		end
		next_st.ov_pulse = ov_evt;
		rc[`GTCU_B_EN] = st.ctl.en;
		rc[`GTCU_B_MODE +: 2] = st.ctl.mode;
		rc[`GTCU_B_TRS] = st.ctl.trs;
		rc[`GTCU_B_POL] = st.ctl.pol;
		rc[`GTCU_B_SINGLE] = st.ctl.single;
		rc[`GTCU_B_TOGEN] = st.ctl.togen;
		rc[`GTCU_B_PRS +: 4] = st.ctl.prescale_select;
		rc[`GTCU_B_PRSACT +: 4] = st.prs_act;
		if (awvalid && awready) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			next_st.w_got = 1'b1;
			next_st.wdata = wdata;
			next_st.wstrb = wstrb;
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (do_wr) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `GTCU_RESP_OKAY;
			case (st.awaddr)
				`GTCU_OFF_RELOAD: begin
					next_st.reload_value = gtcu_merge(st.reload_value, st.wdata[15:0], st.wstrb[1:0]);
				end
				`GTCU_OFF_COUNT: begin
					next_st.cnt = gtcu_merge(st.cnt, st.wdata[15:0], st.wstrb[1:0]);
				end
				`GTCU_OFF_CTRL: begin
					// software write beats the hardware clear of enable
					wv = gtcu_merge(rc, st.wdata[15:0], st.wstrb[1:0]);
					next_st.ctl.en = wv[`GTCU_B_EN];
					next_st.ctl.mode = gtcu_pkg::gtcu_mode_t'(wv[`GTCU_B_MODE +: 2]);
					next_st.ctl.trs = wv[`GTCU_B_TRS];
					next_st.ctl.pol = wv[`GTCU_B_POL];
					next_st.ctl.single = wv[`GTCU_B_SINGLE];
					next_st.ctl.togen = wv[`GTCU_B_TOGEN];
					next_st.ctl.prescale_select = wv[`GTCU_B_PRS +: 4];
				end
				`GTCU_OFF_CHCTL: begin
					wv = gtcu_merge({8'h00, st.chctl}, st.wdata[15:0], st.wstrb[1:0]);
					next_st.chctl = wv[7:0];
				end
				`GTCU_OFF_MASK: begin
					wv = gtcu_merge({10'h000, st.mask}, st.wdata[15:0], st.wstrb[1:0]);
					next_st.mask = wv[5:0];
				end
				`GTCU_OFF_DMA: begin
					wv = gtcu_merge({10'h000, st.dma_en}, st.wdata[15:0], st.wstrb[1:0]);
					next_st.dma_en = wv[5:0];
				end
				`GTCU_OFF_CLEAR: begin
					clr = st.wdata[5:0] & {6{st.wstrb[0]}};
				end
				`GTCU_OFF_ID, `GTCU_OFF_STATUS, `GTCU_OFF_CCR0, `GTCU_OFF_CCR1,
				`GTCU_OFF_CCR2, `GTCU_OFF_CCR3: begin
				end
				default: next_st.bresp = `GTCU_RESP_SLVERR;
			endcase
		end
		// prescale select copied on the enable rising edge, whoever set it
		if (next_st.ctl.en && !st.ctl.en) begin
			next_st.prs_act = next_st.ctl.prescale_select;
			next_st.psc = 15'h0000;
		end
		ev = {ch_ev, ti_evt, ov_evt};
		// an event in the same cycle as its clear wins, so no event is lost
		next_st.status = (st.status & ~clr) | ev;
		next_st.dma_req = |(ev & st.dma_en);
		// irq follows the next values so it never lags the status it reports
		next_st.irq = |(next_st.status & next_st.mask);
		if (!next_st.ctl.togen) begin
			next_st.tog_p = 1'b0;
			next_st.tog_n = 1'b0;
		end else if (!st.tog_p && !st.tog_n) begin
			next_st.tog_p = 1'b1;
			next_st.tog_n = 1'b0;
		end else if (ov_evt) begin
			next_st.tog_p = !st.tog_p;
			next_st.tog_n = !st.tog_n;
		end
		case (araddr)
			`GTCU_OFF_RELOAD: rd = {16'h0000, st.reload_value};
			`GTCU_OFF_COUNT: rd = {16'h0000, st.cnt};
			`GTCU_OFF_CTRL: rd = {16'h0000, rc};
			`GTCU_OFF_ID: rd = {24'h000000, 8'(INSTANCE_ID)};
			`GTCU_OFF_CHCTL: rd = {24'h000000, st.chctl};
			`GTCU_OFF_MASK: rd = {26'h0000000, st.mask};
			`GTCU_OFF_STATUS: rd = {26'h0000000, st.status};
			`GTCU_OFF_CLEAR: rd = 32'h00000000;
			`GTCU_OFF_DMA: rd = {26'h0000000, st.dma_en};
			`GTCU_OFF_CCR0: rd = {16'h0000, ch_ccr[0]};
			`GTCU_OFF_CCR1: rd = {16'h0000, ch_ccr[1]};
			`GTCU_OFF_CCR2: rd = {16'h0000, ch_ccr[2]};
			`GTCU_OFF_CCR3: rd = {16'h0000, ch_ccr[3]};
			default: rd_ok = 1'b0;
		endcase
		if (arvalid && arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd;
			next_st.rresp = rd_ok ? `GTCU_RESP_OKAY : `GTCU_RESP_SLVERR;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.reload_value <= `GTCU_RST_RELOAD;
		end else begin
			st <= next_st;
		end
	end

	assign bresp = st.bresp;
	assign bvalid = st.bvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign rvalid = st.rvalid;
	assign tog_p = st.tog_p;
	assign tog_n = st.tog_n;
	assign overflow_pulse = st.ov_pulse;
	assign dma_req = st.dma_req;
	assign irq = st.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_ov_one_cycle: assert property ((st.ov_pulse && st.reload_value != 16'h0000 &&
		!do_wr) |=> !st.ov_pulse)
		else $error("overflow pulse longer than one cycle");
	a_ov_sets_flag: assert property (st.ov_pulse |-> st.status[`GTCU_ST_OV])
		else $error("overflow did not set its flag");
	a_wrap_zero: assert property ((ov_evt && !do_wr) |=> (st.cnt == 16'h0000))
		else $error("count did not wrap to zero");
	a_single_stop: assert property ((ov_evt && st.ctl.single && !do_wr)
		|=> (!st.ctl.en && st.ov_pulse))
		else $error("single shot did not stop");
	a_prs_pending: assert property (!$stable(st.prs_act)
		|-> ($past(ov_evt) || $rose(st.ctl.en)))
		else $error("prescale changed outside overflow or enable");
	// an overflow tick may load a new prescale, so that tick is left out
	a_div_two: assert property ((tick && !ov_evt && st.prs_act == 4'h1 &&
		st.ctl.en && !do_wr && st.ctl.mode == gtcu_pkg::gtcu_m_timer) |=> !tick)
		else $error("divide by two ticked twice in a row");
	a_count_step: assert property ((tick && !ov_evt && !do_wr)
		|=> (st.cnt == 16'($past(st.cnt) + 16'h0001)))
		else $error("count did not step by one");
	a_reload_live: assert property ((do_wr && st.awaddr == `GTCU_OFF_RELOAD)
		##[1:40] (tick && st.cnt == st.reload_value && !do_wr) |=> st.ov_pulse)
		else $error("new reload not compared at once");
	a_tog_flip: assert property ((st.ov_pulse && st.ctl.togen &&
		$past(st.ctl.togen) && $past(st.tog_p || st.tog_n))
		|-> (st.tog_p != $past(st.tog_p) && st.tog_n == !st.tog_p))
		else $error("toggle output did not invert");
	a_irq_gate: assert property ((ov_evt && st.mask[`GTCU_ST_OV] && !do_wr) |=> irq)
		else $error("unmasked overflow gave no interrupt");
	a_trig_wait: assert property ((st.ctl.mode == gtcu_pkg::gtcu_m_trig &&
		st.ctl.en && !st.started) |-> !tick)
		else $error("trigger start mode counted before trigger");

	c_cont_wrap: cover property (ov_evt && !st.ctl.single ##1 st.ctl.en);
	c_single_stop: cover property (ov_evt && st.ctl.single ##1 !st.ctl.en);
	c_trig_start: cover property (ti_evt ##[1:40] tick);
	c_reload_hit: cover property ((do_wr && st.awaddr == `GTCU_OFF_RELOAD) ##[1:40] st.ov_pulse);
endmodule : gtcu_top

// file: verification/gtcu_tb_top.sv
// Purpose: self-checking bench for one timer counting unit
// Assumes: registers reached over AXI4-Lite, one 40 MHz clock
// Notes: capture pins move only in the channel scenario; status bits are write-one-to-clear
`timescale 1ns/1ps
`include "gtcu_defs.svh"
module gtcu_tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, etr, itr;
	logic awready, wready, bvalid, arready, rvalid, tog_p, tog_n, overflow_pulse, dma_req, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb, ch_in, ch_out;
	logic [1:0] bresp, rresp, rs;
	int err_total, num_checks, n, ov_total, dma_total;

	gtcu_top #(.INSTANCE_ID(2)) i_gtcu_top (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.etr(etr), .itr(itr), .ch_in(ch_in), .ch_out(ch_out), .tog_p(tog_p), .tog_n(tog_n),
		.overflow_pulse(overflow_pulse), .dma_req(dma_req), .irq(irq)
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// pulses are one cycle long, so sample each cycle mid-period
	always @(negedge aclk) begin
		if (overflow_pulse === 1'b1) ov_total++;
		if (dma_req === 1'b1) dma_total++;
	end

	task tally_and_finish;
		if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task hang;
		err_total++;
		$display("CHECK FAILED %0t bus answer never came", $time);
		tally_and_finish();
	endtask : hang

	// handshakes are judged mid-cycle so the ready seen is the one the edge uses
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, pb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int k = 0; k < 64; k++) begin
			@(negedge aclk);
			pa = (awvalid && awready) === 1'b1;
			pw = (wvalid && wready) === 1'b1;
			pb = bvalid === 1'b1;
			rs = bresp;
			@(posedge aclk);
			if (pa) awvalid <= 1'b0;
			if (pw) wvalid <= 1'b0;
			if (pb) begin
				bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : axi_wr

	task rdr(input logic [7:0] a);
		logic pa, pr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int k = 0; k < 64; k++) begin
			@(negedge aclk);
			pa = (arvalid && arready) === 1'b1;
			pr = rvalid === 1'b1;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (pa) arvalid <= 1'b0;
			if (pr) begin
				rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : rdr

	// n ends as cycles waited, equal to lim when no pulse came
	task wait_ov(input int lim);
		n = 0;
		while (n < lim) begin
			@(negedge aclk);
			n++;
			if (overflow_pulse === 1'b1) return;
		end
	endtask : wait_ov

	task irq_is(input logic e);
		@(negedge aclk);
		chk(irq, e);
	endtask : irq_is

	task pulse_trig;
		@(posedge aclk);
		itr <= 1'b1;
		repeat (2) @(posedge aclk);
		itr <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : pulse_trig

	task sc_regs;
		rdr(`GTCU_OFF_RELOAD);
		chk(rd, 32'h0000ffff);
		rdr(`GTCU_OFF_CTRL);
		chk(rd, 32'h0);
		rdr(`GTCU_OFF_ID);
		chk(rd[7:0], 8'h02);
		axi_wr(`GTCU_OFF_COUNT, 32'h12345678);
		rdr(`GTCU_OFF_COUNT);
		chk(rd, 32'h00005678);
		axi_wr(`GTCU_OFF_RELOAD, 32'hffffabcd);
		rdr(`GTCU_OFF_RELOAD);
		chk(rd, 32'h0000abcd);
		axi_wr(8'h40, 32'h1);
		chk(rs, `GTCU_RESP_SLVERR);
		rdr(8'h40);
		chk(rs, `GTCU_RESP_SLVERR);
		chk(rd, 32'h0);
	endtask : sc_regs

	task sc_cont;
		logic t0;
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_RELOAD, 32'h3);
		axi_wr(`GTCU_OFF_MASK, 32'h1);
		axi_wr(`GTCU_OFF_DMA, 32'h1);
		axi_wr(`GTCU_OFF_CTRL, 32'h41);
		wait_ov(100);
		@(negedge aclk);
		chk(overflow_pulse, 1'b0);
		t0 = tog_p;
		chk(tog_n, !t0);
		wait_ov(100);
		chk(n, 3);
		@(negedge aclk);
		chk(tog_p, !t0);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
		axi_wr(`GTCU_OFF_DMA, 32'h0);
		chk(dma_total, ov_total);
		rdr(`GTCU_OFF_STATUS);
		chk(rd[0], 1'b1);
		irq_is(1'b1);
		axi_wr(`GTCU_OFF_MASK, 32'h0);
		irq_is(1'b0);
		axi_wr(`GTCU_OFF_MASK, 32'h1);
		irq_is(1'b1);
		axi_wr(`GTCU_OFF_CLEAR, 32'h1);
		irq_is(1'b0);
		rdr(`GTCU_OFF_STATUS);
		chk(rd[0], 1'b0);
	endtask : sc_cont

	task sc_presc;
		axi_wr(`GTCU_OFF_RELOAD, 32'h7);
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_CTRL, 32'h81);
		wait_ov(500);
		wait_ov(500);
		chk(n, 16);
		axi_wr(`GTCU_OFF_CTRL, 32'h181);
		rdr(`GTCU_OFF_CTRL);
		chk(rd[14:11], 4'h1);
		wait_ov(500);
		wait_ov(500);
		chk(n, 64);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
		rdr(`GTCU_OFF_CTRL);
		chk(rd[14:11], 4'h3);
		axi_wr(`GTCU_OFF_CTRL, 32'h1);
		rdr(`GTCU_OFF_CTRL);
		chk(rd[14:11], 4'h0);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
	endtask : sc_presc

	task sc_single;
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_RELOAD, 32'h2);
		axi_wr(`GTCU_OFF_CTRL, 32'h21);
		wait_ov(100);
		chk(n < 100, 1'b1);
		rdr(`GTCU_OFF_CTRL);
		chk(rd[0], 1'b0);
		rdr(`GTCU_OFF_COUNT);
		chk(rd, 32'h0);
		wait_ov(40);
		chk(n, 40);
	endtask : sc_single

	task sc_reload;
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_RELOAD, 32'd100);
		axi_wr(`GTCU_OFF_CTRL, 32'h1);
		axi_wr(`GTCU_OFF_RELOAD, 32'd20);
		wait_ov(40);
		chk(n < 40, 1'b1);
		wait_ov(100);
		chk(n, 21);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
	endtask : sc_reload

	task sc_modes;
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_RELOAD, 32'd500);
		axi_wr(`GTCU_OFF_CTRL, 32'h0b);
		repeat (3) pulse_trig();
		rdr(`GTCU_OFF_COUNT);
		chk(rd, 32'h3);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_CLEAR, 32'h3f);
		axi_wr(`GTCU_OFF_CTRL, 32'h0d);
		repeat (10) @(posedge aclk);
		rdr(`GTCU_OFF_STATUS);
		chk(rd[1], 1'b0);
		pulse_trig();
		rdr(`GTCU_OFF_STATUS);
		chk(rd[1], 1'b1);
		rdr(`GTCU_OFF_COUNT);
		chk(rd != 32'h0, 1'b1);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_CTRL, 32'h07);
		repeat (10) @(posedge aclk);
		rdr(`GTCU_OFF_COUNT);
		chk(rd, 32'h0);
		etr <= 1'b1;
		repeat (20) @(posedge aclk);
		rdr(`GTCU_OFF_COUNT);
		chk(rd != 32'h0, 1'b1);
		etr <= 1'b0;
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		// inverted polarity: a low gate pin now lets the count run
		axi_wr(`GTCU_OFF_CTRL, 32'h17);
		repeat (20) @(posedge aclk);
		rdr(`GTCU_OFF_COUNT);
		chk(rd != 32'h0, 1'b1);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
	endtask : sc_modes

	task sc_chan;
		axi_wr(`GTCU_OFF_RELOAD, 32'd40);
		axi_wr(`GTCU_OFF_COUNT, 32'h0);
		axi_wr(`GTCU_OFF_CCR0, 32'd10);
		axi_wr(`GTCU_OFF_CLEAR, 32'h3f);
		axi_wr(`GTCU_OFF_CTRL, 32'h1);
		wait_ov(100);
		// compare output is registered, so it trails the count by one cycle
		repeat (3) @(negedge aclk);
		chk(ch_out[0], 1'b1);
		repeat (17) @(negedge aclk);
		chk(ch_out[0], 1'b0);
		axi_wr(`GTCU_OFF_CTRL, 32'h0);
		rdr(`GTCU_OFF_STATUS);
		chk(rd[2], 1'b1);
		axi_wr(`GTCU_OFF_COUNT, 32'h123);
		axi_wr(`GTCU_OFF_CHCTL, 32'h08);
		axi_wr(`GTCU_OFF_CLEAR, 32'h3f);
		ch_in[1] <= 1'b1;
		repeat (8) @(posedge aclk);
		rdr(`GTCU_OFF_CCR1);
		chk(rd, 32'h123);
		rdr(`GTCU_OFF_STATUS);
		chk(rd[3], 1'b1);
		@(negedge aclk);
		chk(ch_out[1], 1'b0);
		axi_wr(`GTCU_OFF_COUNT, 32'h77);
		axi_wr(`GTCU_OFF_CHCTL, 32'h0c);
		ch_in[1] <= 1'b0;
		repeat (8) @(posedge aclk);
		rdr(`GTCU_OFF_CCR1);
		chk(rd, 32'h77);
		axi_wr(`GTCU_OFF_CHCTL, 32'h0);
	endtask : sc_chan

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, etr, itr} = 8'h00;
		{awaddr, araddr, wdata, wstrb, ch_in} = '0;
		{err_total, num_checks, ov_total, dma_total} = {32'd0, 32'd0, 32'd0, 32'd0};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		sc_regs();
		sc_cont();
		sc_presc();
		sc_single();
		sc_reload();
		sc_modes();
		sc_chan();
		tally_and_finish();
	end
endmodule : gtcu_tb_top
